// ### core/vxc_defs.vh
`ifndef VXC_DEFS_VH
`define VXC_DEFS_VH
// ***************************************************************
// register indices
// ***************************************************************
`define VXC_IDX_SYNC_CTL     8'h56
`define VXC_IDX_SYNC_DLY     8'h57
`define VXC_IDX_WIN_CTL      8'h58
`define VXC_IDX_WIN_POS_LO   8'h59
`define VXC_IDX_WIN_POS_HI   8'h5a
`define VXC_IDX_BIOS2        8'h5b
`define VXC_IDX_GOUT         8'h5c
`define VXC_IDX_HOVF         8'h5d
`define VXC_IDX_VOVF         8'h5e
`define VXC_IDX_GNT_POS      8'h5f
// ***************************************************************
// reset values and writable masks
// ***************************************************************
`define VXC_RST_BYTE         8'h00
`define VXC_RST_WIN_POS      16'h000a
`define VXC_MASK_SYNC_CTL    8'h3f
`define VXC_MASK_WIN_POS_HI  8'h03
`define VXC_MASK_HOVF        8'hd7
`define VXC_MASK_VOVF        8'h57
// ***************************************************************
// field positions
// ***************************************************************
`define VXC_B_REMOTE         0
`define VXC_B_CNT525         1
`define VXC_B_CNT625         2
`define VXC_B_SYNC_SEL       3
`define VXC_B_PARITY         4
`define VXC_B_SYNC_DIS       5
`define VXC_B_RAHEAD         2
`define VXC_B_ISA_LATCH      3
`define VXC_B_LIN_EN         4
`define VXC_B_POST_LIM       5
`define VXC_B_SER_LEN        6
`define VXC_B_CYC_LEN        7
// ***************************************************************
// timing counts
// ***************************************************************
`define VXC_LINE_525         12'd910
`define VXC_LINE_625         12'd1135
`define VXC_HT_EXTRA         9'd5
`define VXC_SER_512          10'd512
`define VXC_SER_256          10'd256
`define VXC_CYC_7            3'd7
`define VXC_CYC_6            3'd6
`endif

// ### core/vxc_crtc_ext.v
// What this block does
// [RULE_01] 525 mode: line is 113*8+6 pixel clocks
// [RULE_02] 625 mode: line is 141*8+7 pixel clocks
// [RULE_03] remote vsync fall resets h/v or v only
// [RULE_04] preset bit picks starting frame parity
// [RULE_05] sync disable floats hsync, vsync, blank
// [RULE_06] vertical reset delayed by programmed lines
// [RULE_07] horizontal reset delayed by programmed characters
// [RULE_08] two-bit field selects window size
// [RULE_09] read-ahead cache only when bit set
// [RULE_10] latch host address each isa cycle
// [RULE_11] window decodes only when linear enabled
// [RULE_12] limit bit restricts posted write depth
// [RULE_13] serial port length 512 or 256 words
// [RULE_14] random cycle 7 or 6 memory clocks
// [RULE_15] compare position with size-aligned masking
// [RULE_16] upper match inputs; isa ignores bits 25:24
// [RULE_17] clock select readback from misc bits
// [RULE_18] upper nibble is user general output
// [RULE_19] horizontal overflow supplies six bit-8 values
// [RULE_20] vertical overflow supplies five bit-10 values
// [RULE_21] grant ends at programmed character position
// [RULE_22] host uses index port then data port
// [RULE_23] remote mode turns vsync into input
// [RULE_24] reserved bits ignored; fields reset to defaults
`include "vxc_defs.vh"
module vxc_crtc_ext (
    input  wire        i_clk_sys,
    input  wire        i_reset_n,
    input  wire        i_idx_wr,
    input  wire        i_data_wr,
    input  wire        i_data_rd,
    input  wire [7:0]  i_wdata,
    output reg  [7:0]  o_rdata,
    input  wire [7:0]  i_htotal,
    input  wire        i_interlace,
    input  wire [1:0]  i_misc_clk_sel,
    input  wire [3:0]  i_ext_clk_sel,
    input  wire        i_hsync_src,
    input  wire        i_vsync_src,
    input  wire        i_blank_src,
    input  wire        i_vsync_pin,
    output reg         o_hsync,
    output reg         o_hsync_oe,
    output reg         o_vsync,
    output reg         o_vsync_oe,
    output reg         o_blank,
    output reg         o_blank_oe,
    output reg  [11:0] o_hpix,
    output reg  [10:0] o_vline,
    output reg         o_odd_field,
    output reg         o_hcnt_reset,
    output reg         o_vcnt_reset,
    input  wire [25:16] i_host_addr,
    input  wire        i_addr_strobe,
    input  wire        i_isa_mode,
    input  wire        i_upper_match_a,
    input  wire        i_upper_match_b,
    output reg         o_window_hit,
    output reg  [1:0]  o_window_size,
    output reg         o_read_ahead_en,
    output reg         o_post_depth_limit,
    output reg  [9:0]  o_serial_words,
    output reg  [2:0]  o_random_cycle_mclk,
    output reg  [3:0]  o_gen_out,
    output reg  [5:0]  o_h_ovf8,
    output reg  [4:0]  o_v_ovf10,
    input  wire        i_breq_enable,
    input  wire        i_bus_req,
    output reg         o_bus_grant
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_VDLY = 3'b010;
    localparam [2:0] ST_HDLY = 3'b100;

    reg  [7:0]  idx_q;
    reg  [7:0]  sync_ctl_q;
    reg  [7:0]  sync_dly_q;
    reg  [7:0]  win_ctl_q;
    reg  [15:0] win_pos_q;
    reg  [7:0]  bios2_q;
    reg  [3:0]  gout_q;
    reg  [7:0]  hovf_q;
    reg  [7:0]  vovf_q;
    reg  [7:0]  gnt_pos_q;
    reg         vs_meta_q;
    reg         vs_sync_q;
    reg         vs_prev_q;
    reg  [2:0]  st_q;
    reg  [3:0]  dly_q;
    reg         skip_q;
    reg  [9:0]  addr_lat_q;
    reg  [7:0]  rd_d;
    reg  [11:0] line_len;
    reg  [9:0]  pos_mask;
    wire [9:0]  addr_use;
    wire [8:0]  ht9;
    wire        line_end;
    wire        char_end;
    wire        vs_fall;
    wire        remote;
    wire        sel_v;

    assign remote   = sync_ctl_q[`VXC_B_REMOTE];
    assign sel_v    = sync_ctl_q[`VXC_B_SYNC_SEL];
    assign ht9      = {hovf_q[0], i_htotal};
    // >= so a shorter line mode picked mid-line wraps at once, not at 4095
    assign line_end = (o_hpix >= line_len - 12'd1);
    assign char_end = (o_hpix[2:0] == 3'h7);
    assign vs_fall  = remote & vs_prev_q & ~vs_sync_q;                  // [RULE_03]

    // ***************************************************************
    // indexed register port
    // ***************************************************************
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            idx_q      <= `VXC_RST_BYTE;
            sync_ctl_q <= `VXC_RST_BYTE;                                // [RULE_24]
            sync_dly_q <= `VXC_RST_BYTE;
            win_ctl_q  <= `VXC_RST_BYTE;
            win_pos_q  <= `VXC_RST_WIN_POS;
            bios2_q    <= `VXC_RST_BYTE;
            gout_q     <= 4'h0;
            hovf_q     <= `VXC_RST_BYTE;
            vovf_q     <= `VXC_RST_BYTE;
            gnt_pos_q  <= `VXC_RST_BYTE;
        end else begin
            if (i_idx_wr) begin
                idx_q <= i_wdata;                                       // [RULE_22]
            end
            if (i_data_wr) begin
                case (idx_q)                                            // [RULE_22]
                    `VXC_IDX_SYNC_CTL:   sync_ctl_q <= i_wdata & `VXC_MASK_SYNC_CTL; // [RULE_24]
                    `VXC_IDX_SYNC_DLY:   sync_dly_q <= i_wdata;
                    `VXC_IDX_WIN_CTL:    win_ctl_q <= i_wdata;
                    `VXC_IDX_WIN_POS_LO: win_pos_q[7:0] <= i_wdata;
                    `VXC_IDX_WIN_POS_HI: win_pos_q[15:8] <= i_wdata & `VXC_MASK_WIN_POS_HI;
                    `VXC_IDX_BIOS2:      bios2_q <= i_wdata;
                    `VXC_IDX_GOUT:       gout_q <= i_wdata[7:4];        // [RULE_18]
                    `VXC_IDX_HOVF:       hovf_q <= i_wdata & `VXC_MASK_HOVF; // [RULE_19]
                    `VXC_IDX_VOVF:       vovf_q <= i_wdata & `VXC_MASK_VOVF; // [RULE_20]
                    `VXC_IDX_GNT_POS:    gnt_pos_q <= i_wdata;
                    default: ;
                endcase
            end
        end
    end

    always @* begin
        rd_d = 8'h00;
        case (idx_q)
            `VXC_IDX_SYNC_CTL:   rd_d = sync_ctl_q;
            `VXC_IDX_SYNC_DLY:   rd_d = sync_dly_q;
            `VXC_IDX_WIN_CTL:    rd_d = win_ctl_q;
            `VXC_IDX_WIN_POS_LO: rd_d = win_pos_q[7:0];
            `VXC_IDX_WIN_POS_HI: rd_d = win_pos_q[15:8];
            `VXC_IDX_BIOS2:      rd_d = bios2_q;
            `VXC_IDX_GOUT: begin
                case (i_misc_clk_sel)                                   // [RULE_17]
                    2'h0:    rd_d = {gout_q, 4'h0};
                    2'h1:    rd_d = {gout_q, 4'h1};
                    2'h2:    rd_d = {gout_q, 4'h2};
                    default: rd_d = {gout_q, i_ext_clk_sel};
                endcase
            end
            `VXC_IDX_HOVF:       rd_d = hovf_q;
            `VXC_IDX_VOVF:       rd_d = vovf_q;
            `VXC_IDX_GNT_POS:    rd_d = gnt_pos_q;
            default:             rd_d = 8'h00;
        endcase
    end

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_data_rd) begin
            o_rdata <= rd_d;
        end
    end

    // ***************************************************************
    // horizontal line length
    // ***************************************************************
    always @* begin
        if (sync_ctl_q[`VXC_B_CNT525]) begin
            line_len = `VXC_LINE_525;                                   // [RULE_01]
        end else if (sync_ctl_q[`VXC_B_CNT625]) begin
            line_len = `VXC_LINE_625;                                   // [RULE_02]
        end else begin
            line_len = {ht9 + `VXC_HT_EXTRA, 3'h0};
        end
    end

    // ***************************************************************
    // external sync pin and genlock reset sequence
    // ***************************************************************
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            vs_meta_q <= 1'b1;
            vs_sync_q <= 1'b1;
            vs_prev_q <= 1'b1;
        end else begin
            vs_meta_q <= i_vsync_pin;
            vs_sync_q <= vs_meta_q;
            vs_prev_q <= vs_sync_q;
        end
    end

    // a zero line delay is illegal in remote mode; it is taken as immediate
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            st_q         <= ST_IDLE;
            dly_q        <= 4'h0;
            skip_q       <= 1'b0;
            o_hpix       <= 12'h000;
            o_vline      <= 11'h000;
            o_odd_field  <= 1'b0;
            o_hcnt_reset <= 1'b0;
            o_vcnt_reset <= 1'b0;
        end else begin
            o_hcnt_reset <= 1'b0;
            o_vcnt_reset <= 1'b0;
            o_hpix <= line_end ? 12'h000 : o_hpix + 12'd1;
            if (line_end) begin
                o_vline <= o_vline + 11'd1;
            end
            case (st_q)
                ST_IDLE: begin
                    if (vs_fall) begin
                        skip_q <= sel_v & i_interlace & ~skip_q;        // [RULE_03]
                        if (!(sel_v & i_interlace & skip_q)) begin
                            st_q  <= ST_VDLY;
                            dly_q <= sync_dly_q[3:0];                   // [RULE_06]
                        end
                    end
                end
                ST_VDLY: begin
                    if (dly_q == 4'h0) begin
                        o_vline      <= 11'h000;                        // [RULE_06]
                        o_vcnt_reset <= 1'b1;
                        if (sel_v) begin
                            o_odd_field <= sync_ctl_q[`VXC_B_PARITY];   // [RULE_04]
                        end
                        st_q  <= ST_HDLY;
                        dly_q <= sync_dly_q[7:4];                       // [RULE_07]
                    end else if (line_end) begin
                        dly_q <= dly_q - 4'd1;
                    end
                end
                ST_HDLY: begin
                    if (dly_q == 4'h0) begin
                        if (!sel_v) begin
                            o_hpix       <= 12'h000;                    // [RULE_07]
                            o_hcnt_reset <= 1'b1;                       // [RULE_03]
                        end
                        st_q <= ST_IDLE;
                    end else if (char_end) begin
                        dly_q <= dly_q - 4'd1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
            if (!remote) begin
                st_q <= ST_IDLE;
            end
        end
    end

    // ***************************************************************
    // sync pins
    // ***************************************************************
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_hsync    <= 1'b0;
            o_hsync_oe <= 1'b0;
            o_vsync    <= 1'b0;
            o_vsync_oe <= 1'b0;
            o_blank    <= 1'b0;
            o_blank_oe <= 1'b0;
        end else begin
            o_hsync    <= i_hsync_src;
            o_vsync    <= i_vsync_src;
            o_blank    <= i_blank_src;
            o_hsync_oe <= ~sync_ctl_q[`VXC_B_SYNC_DIS];                 // [RULE_05]
            o_blank_oe <= ~sync_ctl_q[`VXC_B_SYNC_DIS];                 // [RULE_05]
            o_vsync_oe <= ~sync_ctl_q[`VXC_B_SYNC_DIS] & ~remote;       // [RULE_23]
        end
    end

    // ***************************************************************
    // linear window decode
    // ***************************************************************
    always @* begin
        case (win_ctl_q[1:0])                                           // [RULE_15]
            2'h0:    pos_mask = 10'h3ff;
            2'h1:    pos_mask = 10'h3f0;
            2'h2:    pos_mask = 10'h3e0;
            default: pos_mask = 10'h3c0;
        endcase
        if (i_isa_mode) begin
            pos_mask = pos_mask & 10'h0ff;                              // [RULE_16]
        end
    end

    // latching holds the decode stable while an isa cycle lingers
    assign addr_use = win_ctl_q[`VXC_B_ISA_LATCH] ? addr_lat_q : i_host_addr;

    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_lat_q   <= 10'h000;
            o_window_hit <= 1'b0;
        end else begin
            if (i_addr_strobe) begin
                addr_lat_q <= i_host_addr;                              // [RULE_10]
            end
            o_window_hit <= win_ctl_q[`VXC_B_LIN_EN]                    // [RULE_11]
                          & i_upper_match_a & i_upper_match_b           // [RULE_16]
                          & (((addr_use ^ win_pos_q[9:0]) & pos_mask) == 10'h000); // [RULE_15]
        end
    end

    // ***************************************************************
    // memory options, overflow bits, general output
    // ***************************************************************
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_window_size       <= 2'h0;
            o_read_ahead_en     <= 1'b0;
            o_post_depth_limit  <= 1'b0;
            o_serial_words      <= `VXC_SER_512;
            o_random_cycle_mclk <= `VXC_CYC_7;
            o_gen_out           <= 4'h0;
            o_h_ovf8            <= 6'h00;
            o_v_ovf10           <= 5'h00;
        end else begin
            o_window_size      <= win_ctl_q[1:0];                       // [RULE_08]
            o_read_ahead_en    <= win_ctl_q[`VXC_B_RAHEAD];             // [RULE_09]
            o_post_depth_limit <= win_ctl_q[`VXC_B_POST_LIM];           // [RULE_12]
            o_serial_words      <= win_ctl_q[`VXC_B_SER_LEN] ?
                                   `VXC_SER_256 : `VXC_SER_512;         // [RULE_13]
            o_random_cycle_mclk <= win_ctl_q[`VXC_B_CYC_LEN] ?
                                   `VXC_CYC_6 : `VXC_CYC_7;             // [RULE_14]
            o_gen_out <= gout_q;                                        // [RULE_18]
            o_h_ovf8  <= {hovf_q[7:6], hovf_q[4], hovf_q[2:0]};         // [RULE_19]
            o_v_ovf10 <= {vovf_q[6], vovf_q[4], vovf_q[2:0]};           // [RULE_20]
        end
    end

    // ***************************************************************
    // bus grant
    // ***************************************************************
    always @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_bus_grant <= 1'b0;
        end else if (!i_breq_enable) begin
            o_bus_grant <= 1'b0;
        end else if (o_hpix[11:3] == {hovf_q[7], gnt_pos_q}) begin
            o_bus_grant <= 1'b0;                                        // [RULE_21]
        end else if (i_bus_req) begin
            o_bus_grant <= 1'b1;
        end
    end
endmodule // vxc_crtc_ext

// ### test/vxc_crtc_ext_monitor.sv
// ****************************************
// port checker of the extended crtc block
// ****************************************
module vxc_crtc_ext_chk (
    input logic        i_clk_sys,
    input logic        i_reset_n,
    input logic        i_data_rd,
    input logic [7:0]  o_rdata,
    input logic        i_hsync_src,
    input logic        o_hsync,
    input logic        o_hsync_oe,
    input logic        o_vsync_oe,
    input logic        o_blank_oe,
    input logic [11:0] o_hpix,
    input logic        o_vcnt_reset,
    input logic        o_hcnt_reset,
    input logic        i_upper_match_a,
    input logic        i_upper_match_b,
    input logic        o_window_hit,
    input logic        i_breq_enable,
    input logic        o_bus_grant,
    input logic [9:0]  o_serial_words,
    input logic [2:0]  o_random_cycle_mclk
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_reset_n);
    // read data only moves on the edge after a taken read
    a_rdata_hold: assert property (!$past(i_data_rd) |-> $stable(o_rdata))
        else $error("read data moved without a read");
    a_hsync_copy: assert property (o_hsync_oe |-> o_hsync == $past(i_hsync_src))
        else $error("hsync pin lost its source");
    a_pins_float: assert property (o_hsync_oe == o_blank_oe)
        else $error("sync pins disagree on drive");
    a_vsync_dir: assert property (o_vsync_oe |-> o_hsync_oe)
        else $error("vsync driven while sync disabled");
    a_hit_upper: assert property (o_window_hit |-> $past(i_upper_match_a && i_upper_match_b))
        else $error("window hit without upper match");
    a_grant_enable: assert property (!i_breq_enable |=> !o_bus_grant)
        else $error("grant while function disabled");
    a_vreset_pulse: assert property (o_vcnt_reset |=> !o_vcnt_reset)
        else $error("vertical reset pulse too long");
    a_hreset_pulse: assert property ($rose(o_hcnt_reset) |=> $fell(o_hcnt_reset))
        else $error("horizontal reset pulse too long");
    a_line_bound: assert property (o_hpix < 12'd1135)
        else $error("pixel count past longest line");
    a_serial_len: assert property (o_serial_words == 10'd512 || o_serial_words == 10'd256)
        else $error("serial length out of set");
    a_cycle_len: assert property (o_random_cycle_mclk inside {3'd6, 3'd7})
        else $error("random cycle out of set");
endmodule // vxc_crtc_ext_chk
bind vxc_crtc_ext vxc_crtc_ext_chk vxc_crtc_ext_chk_i (.*);

// ### test/vxc_host_model.sv
// ****************************************
// board logic beside the device
// ****************************************
module vxc_host_model #(
    parameter logic [5:0] UPPER_BASE = 6'h00
) (
    input  logic        i_clk_sys,
    input  logic [31:0] i_addr,
    input  logic        i_fall_req,
    output logic        o_match_a,
    output logic        o_match_b,
    output logic        o_vsync_drv
);
    int low_cnt = 0;
    // top address bits are decoded on the board, not in the device
    assign o_match_a = i_addr[31:29] == UPPER_BASE[5:3];
    assign o_match_b = i_addr[28:26] == UPPER_BASE[2:0];
    // reference sync idles high; one request gives one low pulse
    always @(posedge i_clk_sys) begin
        if (i_fall_req) low_cnt <= 40;
        else if (low_cnt != 0) low_cnt <= low_cnt - 1;
    end
    assign o_vsync_drv = (low_cnt == 0);
endmodule // vxc_host_model

// ### test/vxc_crtc_ext_tb.sv
`include "vxc_defs.vh"
`define CHK(nm, e, a) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module vxc_crtc_ext_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // signals
    // ****************************************
    logic i_clk_sys = 0, i_reset_n = 0, i_idx_wr = 0, i_data_wr = 0, i_data_rd = 0;
    logic i_interlace = 0, i_hsync_src = 0, i_vsync_src = 0, i_blank_src = 0;
    logic i_addr_strobe = 0, i_isa_mode = 0, i_upper_match_a, i_upper_match_b;
    logic i_breq_enable = 0, i_bus_req = 0, o_hsync, o_hsync_oe, o_vsync, o_vsync_oe;
    logic o_blank, o_blank_oe, o_odd_field, o_hcnt_reset, o_vcnt_reset, o_window_hit;
    logic o_read_ahead_en, o_post_depth_limit, o_bus_grant, vs_drv, hit;
    logic rd_p1 = 0, rd_p2 = 0, fall_req = 0;
    logic [7:0] i_wdata = 0, o_rdata, i_htotal = 8'h05, d, ev;
    logic [1:0] i_misc_clk_sel = 0, o_window_size;
    logic [3:0] i_ext_clk_sel = 0, o_gen_out;
    logic [11:0] o_hpix;
    logic [10:0] o_vline;
    logic [9:0] o_serial_words, pos, mk;
    logic [2:0] o_random_cycle_mclk;
    logic [5:0] o_h_ovf8, up;
    logic [4:0] o_v_ovf10;
    logic [31:0] seed = 32'd70, haddr = 0;
    logic [7:0] wv[11];
    logic [7:0] expq[$];
    int n_fail = 0, checks_done = 0, cyc = 0, n;
    // the vsync wire: device drives it unless sync is disabled or it listens to the board
    wire i_vsync_pin = o_vsync_oe ? o_vsync : vs_drv;
    wire [25:16] i_host_addr = haddr[25:16];
    localparam logic [7:0] MSK[11] = '{`VXC_MASK_SYNC_CTL, 8'hff, 8'hff, 8'hff,
        `VXC_MASK_WIN_POS_HI, 8'hff, 8'hf0, `VXC_MASK_HOVF, `VXC_MASK_VOVF, 8'hff, 8'h00};
    localparam int LL[3] = '{80, 910, 1135};
    vxc_crtc_ext vxc_crtc_ext_i (.*);
    vxc_host_model vxc_host_model_i (.i_clk_sys(i_clk_sys), .i_addr(haddr),
        .i_fall_req(fall_req), .o_match_a(i_upper_match_a), .o_match_b(i_upper_match_b),
        .o_vsync_drv(vs_drv));
    always #10 i_clk_sys = ~i_clk_sys;
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic step(int k = 1);
        repeat (k) @(posedge i_clk_sys);
        #1;
    endtask
    task automatic wr(logic [7:0] idx, logic [7:0] v);
        i_idx_wr = 1;
        i_wdata = idx;
        step();
        i_idx_wr = 0;
        i_data_wr = 1;
        i_wdata = v;
        step();
        i_data_wr = 0;
    endtask
    task automatic rd(logic [7:0] idx, logic [7:0] e);
        i_idx_wr = 1;
        i_wdata = idx;
        step();
        i_idx_wr = 0;
        i_data_rd = 1;
        expq.push_back(e);
        step();
        i_data_rd = 0;
    endtask
    task automatic wait_for(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s !== lvl && n < lim) begin
            step();
            n++;
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // ****************************************
    // result watcher and timeout
    // ****************************************
    always @(posedge i_clk_sys) begin
        rd_p1 <= i_data_rd;
        rd_p2 <= rd_p1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            n_fail++;
            end_sim();
        end
    end
    always @(negedge i_clk_sys) begin
        if (rd_p2) begin
            ev = expq.pop_front();
            `CHK("read data", ev, o_rdata)
        end
    end
    always @(posedge i_clk_sys) #1 {i_hsync_src, i_vsync_src, i_blank_src} = cyc[4:2];
    // ****************************************
    // scenarios
    // ****************************************
    initial begin
        step(3);
        i_reset_n = 1;
        for (int k = 0; k < 11; k++) rd(8'(8'h56 + k), k == 3 ? 8'h0a : 8'h00);
        for (int k = 0; k < 11; k++) begin
            wv[k] = xs();
            wr(8'(8'h56 + k), wv[k]);
            rd(8'(8'h56 + k), wv[k] & MSK[k]);
        end
        `CHK("gen out", wv[6][7:4], o_gen_out)
        `CHK("h ovf", {wv[7][7:6], wv[7][4], wv[7][2:0]}, o_h_ovf8)
        `CHK("v ovf", {wv[8][6], wv[8][4], wv[8][2:0]}, o_v_ovf10)
        for (int m = 0; m < 4; m++) begin
            d = xs();
            i_misc_clk_sel = 2'(m);
            i_ext_clk_sel = d[3:0];
            rd(8'h5c, {wv[6][7:4], m == 3 ? d[3:0] : 4'(m)});
        end
        pos = 10'({xs(), xs()});
        wr(8'h59, pos[7:0]);
        wr(8'h5a, {6'h00, pos[9:8]});
        for (int k = 0; k < 16; k++) begin
            d = xs();
            d[4] = d[4] | k[0];
            wr(8'h58, d);
            mk = 10'h3ff << (d[1:0] == 2'b00 ? 0 : d[1:0] + 3);
            if (k[1]) mk = mk & 10'h0ff;
            up = (k % 3 == 0) ? 6'(xs()) : 6'h00;
            haddr = {up, pos ^ (10'({xs(), xs()}) & (k[2] ? ~mk : 10'h3ff)), 16'h0000};
            hit = d[4] && up == 6'h00 && ((haddr[25:16] ^ pos) & mk) == 10'h000;
            i_isa_mode = k[1];
            i_addr_strobe = 1;
            step();
            i_addr_strobe = 0;
            step(3);
            `CHK("window hit", hit, o_window_hit)
            `CHK("window size", d[1:0], o_window_size)
            `CHK("read ahead", d[2], o_read_ahead_en)
            `CHK("post limit", d[5], o_post_depth_limit)
            `CHK("serial", d[6] ? 10'd256 : 10'd512, o_serial_words)
            `CHK("cycle", d[7] ? 3'd6 : 3'd7, o_random_cycle_mclk)
        end
        wr(8'h5d, 8'h00);
        for (int k = 0; k < 3; k++) begin
            wr(8'h56, 8'(2 * k));
            step(4);
            n = 0;
            while (o_hpix !== 12'd0 && n < 2000) begin
                step();
                n++;
            end
            n = 0;
            do begin
                step();
                n++;
            end while (o_hpix !== 12'd0 && n < 2000);
            `CHK("line length", LL[k], n)
        end
        wr(8'h56, 8'h20);
        step(3);
        `CHK("sync float", 3'b000, {o_hsync_oe, o_vsync_oe, o_blank_oe})
        wr(8'h57, 8'h22);
        wr(8'h56, 8'h01);
        step(3);
        `CHK("sync drive", 3'b101, {o_hsync_oe, o_vsync_oe, o_blank_oe})
        fall_req = 1;
        step();
        fall_req = 0;
        wait_for(o_vcnt_reset, 1'b1, 400);
        `CHK("v delay", 1'b1, n >= 80 && n <= 175)
        wait_for(o_hcnt_reset, 1'b1, 60);
        `CHK("h delay", 1'b1, n >= 8 && n <= 20)
        for (int p = 0; p < 2; p++) begin
            wr(8'h56, p ? 8'h19 : 8'h09);
            step(60);
            fall_req = 1;
            step();
            fall_req = 0;
            wait_for(o_vcnt_reset, 1'b1, 400);
            step();
            `CHK("start field", 1'(p), o_odd_field)
            wait_for(o_hcnt_reset, 1'b1, 60);
            `CHK("v only", 60, n)
        end
        wr(8'h56, 8'h00);
        wr(8'h5f, 8'h04);
        i_breq_enable = 1;
        i_bus_req = 1;
        wait_for(o_bus_grant, 1'b1, 200);
        wait_for(o_bus_grant, 1'b0, 200);
        `CHK("grant end", 9'd4, o_hpix[11:3])
        i_breq_enable = 0;
        step(2);
        `CHK("grant off", 1'b0, o_bus_grant)
        step(5);
        end_sim();
    end
endmodule // vxc_crtc_ext_tb
